// ### bench/toss_host_model.sv
`timescale 1ns/1ns
`default_nettype none
module toss_host_model (
    input  wire logic        clk_in,
    output logic             psel_out,
    output logic             penable_out,
    output logic             pwrite_out,
    output logic      [11:0] paddr_out,
    output logic      [31:0] pwdata_out,
    input  wire logic [31:0] prdata_in,
    input  wire logic        pready_in,
    input  wire logic        pslverr_in
);
    initial begin
        psel_out = 1'h0;
        penable_out = 1'h0;
        pwrite_out = 1'h0;
        paddr_out = 12'h0;
        pwdata_out = 32'h0;
    end
    // values handed in are kept in range by the caller; released lines flip so stale data shows
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk_in);
        psel_out <= 1'h1;
        penable_out <= 1'h0;
        pwrite_out <= w;
        paddr_out <= a;
        pwdata_out <= d;
        @(posedge clk_in);
        penable_out <= 1'h1;
        do @(posedge clk_in); while (pready_in !== 1'h1);
        q = prdata_in;
        e = pslverr_in;
        psel_out <= 1'h0;
        penable_out <= 1'h0;
        paddr_out <= ~a;
        pwdata_out <= ~d;
    endtask
endmodule
`default_nettype wire

// ### bench/toss_sequencer_top_properties.sv
`timescale 1ns/1ns
`default_nettype none
module toss_sequencer_props #(
    parameter int unsigned TICK_REPEAT_SETTING_CMD = 10
) (
    input wire logic        CLK_IN,
    input wire logic        RST_N_IN,
    input wire logic        PSEL_IN,
    input wire logic        PENABLE_IN,
    input wire logic        PWRITE_IN,
    input wire logic [11:0] PADDR_IN,
    input wire logic [31:0] PWDATA_IN,
    input wire logic [31:0] PRDATA_OUT,
    input wire logic        PREADY_OUT,
    input wire logic        PSLVERR_OUT,
    input wire logic        OUT_EN_OUT
);
    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);
    logic take;
    logic unmapped;
    assign take = PSEL_IN && PENABLE_IN && !PREADY_OUT;
    assign unmapped = (PADDR_IN[11:5] != 7'h00);
    property p_answer; take |=> PREADY_OUT; endproperty
    a_answer: assert property (p_answer) else $error("ready missing after access");
    property p_pulse; PREADY_OUT |=> !PREADY_OUT; endproperty
    a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
    property p_only_access; PREADY_OUT |-> PSEL_IN && PENABLE_IN; endproperty
    a_only_access: assert property (p_only_access) else $error("ready outside access");
    property p_err_with_ready; PSLVERR_OUT |-> PREADY_OUT; endproperty
    a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
    property p_unmapped; take && unmapped && !PWRITE_IN |=> PSLVERR_OUT && PRDATA_OUT == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
    property p_mapped; take && !unmapped && !PWRITE_IN && PADDR_IN[1:0] == 2'h0 |=> !PSLVERR_OUT;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped read refused");
    property p_rdata_hold; !$rose(PREADY_OUT) |-> $stable(PRDATA_OUT); endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    // output register updates on the same edge the write lands; sampled low from the one after
    property p_disable;
        PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN && PADDR_IN == 12'h000 && !PWDATA_IN[0]
        |-> ##2 !OUT_EN_OUT [*3];
    endproperty
    a_disable: assert property (p_disable) else $error("output on after disable");
endmodule
bind toss_sequencer_top toss_sequencer_props #(.TICK_REPEAT_SETTING_CMD(TICK_REPEAT_SETTING_CMD)) toss_sequencer_props_i (
    .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT), .OUT_EN_OUT(OUT_EN_OUT));
`default_nettype wire

// ### bench/toss_sequencer_top_tb.sv
`timescale 1ns/1ns
`default_nettype none
module toss_sequencer_top_tb;
    logic        clk = 1'h0;
    logic        rst_n = 1'h0;
    logic        psel, penable, pwrite, pready, pslverr, out_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata;
    int          fail_count = 0;
    int          cmp_count = 0;
    always #20 clk = ~clk;
    toss_sequencer_top #(.TABLE_DEPTH(2048), .TICK_REPEAT_SETTING_CMD(10)) toss_sequencer_top_i (
        .CLK_IN(clk), .RST_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
        .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
        .PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .OUT_EN_OUT(out_en));
    toss_host_model toss_host_model_i (
        .clk_in(clk), .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite),
        .paddr_out(paddr), .pwdata_out(pwdata), .prdata_in(prdata), .pready_in(pready),
        .pslverr_in(pslverr));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        toss_host_model_i.xfer(1'h1, {4'h0, a}, d, q, e);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] q;
        logic        e;
        toss_host_model_i.xfer(1'h0, a, 32'h0, q, e);
        check(q, exp);
        check({31'h0, e}, {31'h0, exp_err});
    endtask
    task automatic t_reset_vals;
        rd({4'h0, toss_pkg::CTRL_OFF}, 32'h0, 1'h0);
        rd({4'h0, toss_pkg::STEP_CNT_OFF}, 32'h1, 1'h0);
        rd({4'h0, toss_pkg::REPEAT_OFF}, 32'h1, 1'h0);
        rd({4'h0, toss_pkg::END_OFF}, 32'h0, 1'h0);
        rd({4'h0, toss_pkg::START_OFF}, 32'h0, 1'h0);
        check({31'h0, out_en}, 32'h0);
    endtask
    task automatic t_config;
        wr(toss_pkg::STEP_CNT_OFF, 32'h800);
        rd({4'h0, toss_pkg::STEP_CNT_OFF}, 32'h800, 1'h0);
        wr(toss_pkg::REPEAT_OFF, 32'h8001869F);
        rd({4'h0, toss_pkg::REPEAT_OFF}, 32'h8001869F, 1'h0);
        wr(toss_pkg::REPEAT_OFF, 32'h0001869F);
        rd({4'h0, toss_pkg::REPEAT_OFF}, 32'h0001869F, 1'h0);
        for (int e = 0; e < 3; e++) begin
            wr(toss_pkg::END_OFF, 32'(e));
            rd({4'h0, toss_pkg::END_OFF}, 32'(e), 1'h0);
        end
        wr(toss_pkg::START_OFF, 32'h7FF);
        rd({4'h0, toss_pkg::START_OFF}, 32'h7FF, 1'h0);
        rd(12'h100, 32'h0, 1'h1);
        wr(toss_pkg::CTRL_OFF, 32'h3);
        rd({4'h0, toss_pkg::CTRL_OFF}, 32'h1, 1'h0);
        wr(toss_pkg::CTRL_OFF, 32'h0);
        rd({4'h0, toss_pkg::CTRL_OFF}, 32'h0, 1'h0);
    endtask
    task automatic t_table;
        wr(toss_pkg::TBL_IDX_OFF, 32'h7FF);
        wr(toss_pkg::TBL_DATA_OFF, 32'h1012C);
        wr(toss_pkg::TBL_IDX_OFF, 32'h0);
        wr(toss_pkg::TBL_DATA_OFF, 32'h1);
        rd({4'h0, toss_pkg::TBL_DATA_OFF}, 32'h1, 1'h0);
        wr(toss_pkg::TBL_IDX_OFF, 32'h7FF);
        rd({4'h0, toss_pkg::TBL_DATA_OFF}, 32'h1012C, 1'h0);
    endtask
    // step 5 is on for 10 repeat_setting_cmd, step 6 off for 20; a pass takes 30 repeat_setting_cmd from edge 3
    task automatic watch(input logic endless, input logic endv);
        int   p;
        logic e;
        for (int m = 1; m <= 150; m++) begin
            @(negedge clk);
            p = (m - 3) % 30;
            e = (p < 10);
            // end state is registered on the edge closing pass two, seen from m = 61
            if (!endless && m >= 61) e = endv;
            if (m >= 4 && p != 29 && p != 0 && p != 9 && p != 10)
                check({31'h0, out_en}, {31'h0, e});
        end
    endtask
    task automatic t_runs;
        wr(toss_pkg::TBL_IDX_OFF, 32'h5);
        wr(toss_pkg::TBL_DATA_OFF, 32'h10001);
        wr(toss_pkg::TBL_IDX_OFF, 32'h6);
        wr(toss_pkg::TBL_DATA_OFF, 32'h2);
        wr(toss_pkg::START_OFF, 32'h5);
        wr(toss_pkg::STEP_CNT_OFF, 32'h2);
        wr(toss_pkg::REPEAT_OFF, 32'h2);
        for (int e = 0; e < 3; e++) begin
            wr(toss_pkg::END_OFF, 32'(e));
            wr(toss_pkg::CTRL_OFF, 32'h3);
            watch(1'h0, e == 1);
        end
        wr(toss_pkg::REPEAT_OFF, 32'h80000002);
        wr(toss_pkg::END_OFF, 32'h1);
        wr(toss_pkg::CTRL_OFF, 32'h3);
        watch(1'h1, 1'h1);
        wr(toss_pkg::CTRL_OFF, 32'h0);
        repeat (3) @(negedge clk);
        for (int m = 0; m < 30; m++) begin
            @(negedge clk);
            check({31'h0, out_en}, 32'h0);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'h1;
        t_reset_vals;
        t_config;
        t_table;
        t_runs;
        wrap_up;
    end
    // the full run needs about 850 repeat_setting_cmd; this leaves wide margin
    initial begin
        #(40 * 6000);
        fail_count++;
        wrap_up;
    end
endmodule
`default_nettype wire

// ### src/toss_pkg.sv
// Contract
// - step table indexed 0..2047, each entry writable
// - hold duration is 1..300 whole seconds
// - entry holds on/off state driven while active
// - steps per pass configurable 1..2048
// - step count reads back last value written
// - finite mode runs 1..99999 passes
// - endless mode restarts forever, ignores pass count
// - repeat readback gives mode and pass count
// - finite end forces on, off or holds last
// - termination behaviour reads back its encoding
// - master enable, settable and readable
// - first step index configurable 0..2047
// - restart begins again from first step
package toss_pkg;

    localparam int unsigned CLK_HZ       = 25_000_000;
    localparam int unsigned TICK_MS      = 1000;
    localparam int unsigned TICK_REPEAT_SETTING_CMD  = CLK_HZ / 1000 * TICK_MS;

    localparam int unsigned TABLE_DEPTH  = 2048;
    localparam int unsigned DUR_W        = 9;
    localparam int unsigned PASS_W       = 17;
    localparam int unsigned STEPS_W      = 12;
    localparam int unsigned ADDR_W       = 8;

    // byte offsets on the register bus
    localparam logic [7:0] CTRL_OFF      = 8'h00;
    localparam logic [7:0] STEP_CNT_OFF  = 8'h04;
    localparam logic [7:0] REPEAT_OFF    = 8'h08;
    localparam logic [7:0] END_OFF       = 8'h0C;
    localparam logic [7:0] START_OFF     = 8'h10;
    localparam logic [7:0] TBL_IDX_OFF   = 8'h14;
    localparam logic [7:0] TBL_DATA_OFF  = 8'h18;
    localparam logic [7:0] STATUS_OFF    = 8'h1C;

    // field positions
    localparam int unsigned CTRL_EN_BIT      = 0;
    localparam int unsigned CTRL_RESTART_BIT = 1;
    localparam int unsigned REPEAT_MODE_BIT  = 31;
    localparam int unsigned TBL_STATE_BIT    = 16;
    localparam int unsigned STS_RUN_BIT      = 0;
    localparam int unsigned STS_DONE_BIT     = 1;
    localparam int unsigned STS_OUT_BIT      = 2;
    localparam int unsigned STS_IDX_LSB      = 16;

    // reset values
    localparam logic [STEPS_W-1:0] STEPS_RST  = 12'h001;
    localparam logic [PASS_W-1:0]  PASSES_RST = 17'h00001;
    localparam logic [DUR_W-1:0]   DUR_RST    = 9'h001;

    typedef enum logic [1:0] {
        TOSS_END_OFF  = 2'h0,
        TOSS_END_ON   = 2'h1,
        TOSS_END_LAST = 2'h2
    } toss_end_t;

    typedef enum logic [1:0] {
        TOSS_IDLE = 2'b00,
        TOSS_RUN  = 2'b01,
        TOSS_DONE = 2'b11
    } toss_state_t;

endpackage

// ### src/toss_sequencer_top.sv
`timescale 1ns/1ns
`default_nettype none
module toss_sequencer_top #(
    parameter int unsigned TABLE_DEPTH = toss_pkg::TABLE_DEPTH,
    parameter int unsigned TICK_REPEAT_SETTING_CMD = toss_pkg::TICK_REPEAT_SETTING_CMD
) (
    input  wire logic        CLK_IN,
    input  wire logic        RST_N_IN,
    input  wire logic        PSEL_IN,
    input  wire logic        PENABLE_IN,
    input  wire logic        PWRITE_IN,
    input  wire logic [11:0] PADDR_IN,
    input  wire logic [31:0] PWDATA_IN,
    output logic      [31:0] PRDATA_OUT,
    output logic             PREADY_OUT,
    output logic             PSLVERR_OUT,
    output logic             OUT_EN_OUT
);
    localparam int unsigned IDX_W  = $clog2(TABLE_DEPTH);
    localparam int unsigned TICK_W = (TICK_REPEAT_SETTING_CMD > 1) ? $clog2(TICK_REPEAT_SETTING_CMD) : 1;
    localparam int unsigned DUR_W  = toss_pkg::DUR_W;
    localparam int unsigned PASS_W = toss_pkg::PASS_W;
    localparam int unsigned STP_W  = toss_pkg::STEPS_W;
    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_REPEAT_SETTING_CMD - 1);

    generate
        if (TABLE_DEPTH < 2 || (1 << IDX_W) != TABLE_DEPTH || IDX_W > STP_W - 1) begin : g_chk_depth
            $error("table depth must be a power of two up to 2048");
        end
        if (TICK_REPEAT_SETTING_CMD < 1) begin : g_chk_tick
            $error("tick period must be at least one cycle");
        end
    endgenerate

    typedef struct packed {
        toss_pkg::toss_state_t state;
        logic                  enable;
        logic                  endless;
        logic [PASS_W-1:0]     passes;
        toss_pkg::toss_end_t   end_mode;
        logic [STP_W-1:0]      steps;
        logic [IDX_W-1:0]      start_idx;
        logic [IDX_W-1:0]      tbl_idx;
        logic [IDX_W-1:0]      cur_idx;
        logic [STP_W-1:0]      step_num;
        logic [PASS_W-1:0]     pass_num;
        logic [DUR_W-1:0]      sec_cnt;
        logic [TICK_W-1:0]     tick_cnt;
        logic                  out_en;
        logic                  pready;
        logic                  pslverr;
        logic [31:0]           prdata;
    } toss_top_t;

    localparam toss_top_t RST_VAL = '{
        state:    toss_pkg::TOSS_IDLE,
        end_mode: toss_pkg::TOSS_END_OFF,
        steps:    toss_pkg::STEPS_RST,
        passes:   toss_pkg::PASSES_RST,
        default:  '0
    };

    toss_top_t s_reg;
    toss_top_t s_next;

    toss_tbl_if #(.IDX_W(IDX_W)) tbl ();

    toss_step_table #(
        .DEPTH (TABLE_DEPTH)
    ) u_table (
        .clk_in   (CLK_IN),
        .rst_n_in (RST_N_IN),
        .tbl      (tbl.mem)
    );

    // decodes an exact byte address; shared by the read mux and the write path
    function automatic logic reg_hit(input logic [11:0] addr, input logic [7:0] off);
        return (addr[11:8] == 4'h0) && (addr[7:0] == off);
    endfunction

    function automatic logic addr_mapped(input logic [11:0] addr);
        return reg_hit(addr, toss_pkg::CTRL_OFF)     || reg_hit(addr, toss_pkg::STEP_CNT_OFF) ||
               reg_hit(addr, toss_pkg::REPEAT_OFF)   || reg_hit(addr, toss_pkg::END_OFF)      ||
               reg_hit(addr, toss_pkg::START_OFF)    || reg_hit(addr, toss_pkg::TBL_IDX_OFF)  ||
               reg_hit(addr, toss_pkg::TBL_DATA_OFF) || reg_hit(addr, toss_pkg::STATUS_OFF);
    endfunction

    localparam int unsigned STS_IDX_HI = toss_pkg::STS_IDX_LSB + IDX_W - 1;

    logic acc_start;
    logic acc_done;
    logic wr_done;
    logic tick;
    logic step_end;
    logic pass_end;
    logic run_end;
    logic start_req;
    logic reconfig;
    logic [31:0] rd_word;

    always_comb begin
        acc_start = PSEL_IN && PENABLE_IN && !s_reg.pready;
        acc_done  = PSEL_IN && PENABLE_IN && s_reg.pready;
        wr_done   = acc_done && PWRITE_IN;
        tick      = (s_reg.tick_cnt == TICK_LAST);
        step_end  = tick && (DUR_W'(s_reg.sec_cnt + 1'b1) >= tbl.seq_dur);
        pass_end  = step_end && (STP_W'(s_reg.step_num + 1'b1) >= s_reg.steps);
        run_end   = pass_end && !s_reg.endless && (s_reg.pass_num >= s_reg.passes);

        // restart strobe with the enable bit set, or a fresh enable, both launch a run
        start_req = wr_done && reg_hit(PADDR_IN, toss_pkg::CTRL_OFF) &&
                    PWDATA_IN[toss_pkg::CTRL_EN_BIT] &&
                    (PWDATA_IN[toss_pkg::CTRL_RESTART_BIT] || !s_reg.enable);
        reconfig  = wr_done && (reg_hit(PADDR_IN, toss_pkg::STEP_CNT_OFF) ||
                                reg_hit(PADDR_IN, toss_pkg::REPEAT_OFF)   ||
                                reg_hit(PADDR_IN, toss_pkg::END_OFF)      ||
                                reg_hit(PADDR_IN, toss_pkg::START_OFF));

        rd_word = 32'h0000_0000;
        if (reg_hit(PADDR_IN, toss_pkg::CTRL_OFF)) begin
            rd_word[toss_pkg::CTRL_EN_BIT] = s_reg.enable;
        end
        if (reg_hit(PADDR_IN, toss_pkg::STEP_CNT_OFF)) begin
            rd_word[STP_W-1:0] = s_reg.steps;
        end
        if (reg_hit(PADDR_IN, toss_pkg::REPEAT_OFF)) begin
            rd_word[toss_pkg::REPEAT_MODE_BIT] = s_reg.endless;
            rd_word[PASS_W-1:0]                = s_reg.passes;
        end
        if (reg_hit(PADDR_IN, toss_pkg::END_OFF)) begin
            rd_word[1:0] = s_reg.end_mode;
        end
        if (reg_hit(PADDR_IN, toss_pkg::START_OFF)) begin
            rd_word[IDX_W-1:0] = s_reg.start_idx;
        end
        if (reg_hit(PADDR_IN, toss_pkg::TBL_IDX_OFF)) begin
            rd_word[IDX_W-1:0] = s_reg.tbl_idx;
        end
        if (reg_hit(PADDR_IN, toss_pkg::TBL_DATA_OFF)) begin
            rd_word[toss_pkg::TBL_STATE_BIT] = tbl.host_state;
            rd_word[DUR_W-1:0]               = tbl.host_dur;
        end
        if (reg_hit(PADDR_IN, toss_pkg::STATUS_OFF)) begin
            rd_word[toss_pkg::STS_RUN_BIT]  = (s_reg.state == toss_pkg::TOSS_RUN);
            rd_word[toss_pkg::STS_DONE_BIT] = (s_reg.state == toss_pkg::TOSS_DONE);
            rd_word[toss_pkg::STS_OUT_BIT]  = s_reg.out_en;
            rd_word[STS_IDX_HI:toss_pkg::STS_IDX_LSB] = s_reg.cur_idx;
        end
    end

    // table port drive
    always_comb begin
        tbl.wr_en    = wr_done && reg_hit(PADDR_IN, toss_pkg::TBL_DATA_OFF);
        tbl.wr_idx   = s_reg.tbl_idx;
        tbl.wr_state = PWDATA_IN[toss_pkg::TBL_STATE_BIT];
        tbl.wr_dur   = PWDATA_IN[DUR_W-1:0];
        tbl.seq_idx  = s_reg.cur_idx;
        tbl.host_idx = s_reg.tbl_idx;
    end

    always_comb begin
        s_next = s_reg;

        // bus slave: one wait state, answer on the following edge
        if (acc_start) begin
            s_next.pready  = 1'b1;
            s_next.pslverr = !addr_mapped(PADDR_IN);
            s_next.prdata  = PWRITE_IN ? 32'h0000_0000 : rd_word;
        end else begin
            s_next.pready  = 1'b0;
            s_next.pslverr = 1'b0;
        end

        if (wr_done) begin
            if (reg_hit(PADDR_IN, toss_pkg::CTRL_OFF)) begin
                s_next.enable = PWDATA_IN[toss_pkg::CTRL_EN_BIT];
            end
            if (reg_hit(PADDR_IN, toss_pkg::STEP_CNT_OFF)) begin
                s_next.steps = PWDATA_IN[STP_W-1:0];
            end
            if (reg_hit(PADDR_IN, toss_pkg::REPEAT_OFF)) begin
                s_next.endless = PWDATA_IN[toss_pkg::REPEAT_MODE_BIT];
                s_next.passes  = PWDATA_IN[PASS_W-1:0];
            end
            if (reg_hit(PADDR_IN, toss_pkg::END_OFF)) begin
                s_next.end_mode = toss_pkg::toss_end_t'(PWDATA_IN[1:0]);
            end
            if (reg_hit(PADDR_IN, toss_pkg::START_OFF)) begin
                s_next.start_idx = PWDATA_IN[IDX_W-1:0];
            end
            if (reg_hit(PADDR_IN, toss_pkg::TBL_IDX_OFF)) begin
                s_next.tbl_idx = PWDATA_IN[IDX_W-1:0];
            end
        end

        // seconds prescaler, restarted with each run so the first second is whole
        s_next.tick_cnt = tick ? '0 : TICK_W'(s_reg.tick_cnt + 1'b1);

        unique case (s_reg.state)
            toss_pkg::TOSS_IDLE: begin
                s_next.out_en = 1'b0;
            end
            toss_pkg::TOSS_RUN: begin
                s_next.out_en = tbl.seq_state;
                if (tick) begin
                    s_next.sec_cnt = DUR_W'(s_reg.sec_cnt + 1'b1);
                end
                if (step_end) begin
                    s_next.sec_cnt  = '0;
                    s_next.cur_idx  = IDX_W'(s_reg.cur_idx + 1'b1);
                    s_next.step_num = STP_W'(s_reg.step_num + 1'b1);
                end
                if (pass_end) begin
                    s_next.cur_idx  = s_reg.start_idx;
                    s_next.step_num = '0;
                    s_next.pass_num = PASS_W'(s_reg.pass_num + 1'b1);
                end
                if (run_end) begin
                    s_next.state = toss_pkg::TOSS_DONE;
                    unique case (s_reg.end_mode)
                        toss_pkg::TOSS_END_ON:  s_next.out_en = 1'b1;
                        toss_pkg::TOSS_END_OFF: s_next.out_en = 1'b0;
                        default:                s_next.out_en = s_reg.out_en;
                    endcase
                end
            end
            toss_pkg::TOSS_DONE: begin
                s_next.out_en = s_reg.out_en;
            end
            default: begin
                s_next.state = toss_pkg::TOSS_IDLE;
            end
        endcase

        // reconfiguration drops a finished run back to idle
        if (reconfig && s_reg.state == toss_pkg::TOSS_DONE) begin
            s_next.state = toss_pkg::TOSS_IDLE;
        end

        // disable wins over everything; a restart bit in the same write is ignored since enable is clear
        if (wr_done && reg_hit(PADDR_IN, toss_pkg::CTRL_OFF) &&
            !PWDATA_IN[toss_pkg::CTRL_EN_BIT]) begin
            s_next.state  = toss_pkg::TOSS_IDLE;
            // output drops on the next edge, not one later through the idle branch
            s_next.out_en = 1'b0;
        end

        if (start_req) begin
            s_next.state    = toss_pkg::TOSS_RUN;
            s_next.cur_idx  = s_reg.start_idx;
            s_next.step_num = '0;
            s_next.pass_num = PASS_W'(1'b1);
            s_next.sec_cnt  = '0;
            s_next.tick_cnt = '0;
        end
    end

    always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
            s_reg <= RST_VAL;
        end else begin
            s_reg <= s_next;
        end
    end

    assign PRDATA_OUT  = s_reg.prdata;
    assign PREADY_OUT  = s_reg.pready;
    assign PSLVERR_OUT = s_reg.pslverr;
    assign OUT_EN_OUT  = s_reg.out_en;

endmodule
`default_nettype wire

// ### src/toss_step_table.sv
`timescale 1ns/1ns
`default_nettype none
module toss_step_table #(
    parameter int unsigned DEPTH = toss_pkg::TABLE_DEPTH
) (
    input  wire logic clk_in,
    input  wire logic rst_n_in,
    toss_tbl_if.mem   tbl
);
    localparam int unsigned EW = toss_pkg::DUR_W + 1;

    typedef struct packed {
        logic [DEPTH-1:0][EW-1:0] entry;
    } toss_tbl_t;

    toss_tbl_t s_reg;
    toss_tbl_t s_next;

    always_comb begin
        s_next = s_reg;
        if (tbl.wr_en) begin
            s_next.entry[tbl.wr_idx] = {tbl.wr_state, tbl.wr_dur};
        end
    end

    // two combinational read ports: the sequencer never waits on host reads
    assign {tbl.seq_state, tbl.seq_dur}   = s_reg.entry[tbl.seq_idx];
    assign {tbl.host_state, tbl.host_dur} = s_reg.entry[tbl.host_idx];

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            for (int i = 0; i < DEPTH; i++) begin
                s_reg.entry[i] <= {1'b0, toss_pkg::DUR_RST};
            end
        end else begin
            s_reg <= s_next;
        end
    end
endmodule
`default_nettype wire

// ### src/toss_tbl_if.sv
`timescale 1ns/1ns
`default_nettype none
interface toss_tbl_if #(parameter int unsigned IDX_W = 11);
    logic                      wr_en;
    logic [IDX_W-1:0]          wr_idx;
    logic                      wr_state;
    logic [toss_pkg::DUR_W-1:0] wr_dur;
    logic [IDX_W-1:0]          seq_idx;
    logic                      seq_state;
    logic [toss_pkg::DUR_W-1:0] seq_dur;
    logic [IDX_W-1:0]          host_idx;
    logic                      host_state;
    logic [toss_pkg::DUR_W-1:0] host_dur;

    modport ctl (output wr_en, wr_idx, wr_state, wr_dur, seq_idx, host_idx,
                 input  seq_state, seq_dur, host_state, host_dur);
    modport mem (input  wr_en, wr_idx, wr_state, wr_dur, seq_idx, host_idx,
                 output seq_state, seq_dur, host_state, host_dur);
endinterface
`default_nettype wire
